// file: logic/ufi_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufi_regs.svh"
module ufi_core #(
    parameter int TMO_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire ufi_pkg::ufi_fifo_t fifo,
    input wire ufi_pkg::ufi_err_t err,
    input wire logic rx_fifo_rd,
    input wire logic tx_fifo_wr,
    output logic rx_data_ready_flag,
    output logic tx_holding_empty_flag,
    output logic host_interrupt_line,
    output logic irq
);
    import ufi_pkg::*;
    // control and status registers
    logic [7:0] ctrl_q, ctrl_d;
    logic [3:0] err_q, err_d;
    logic [3:0] ist_q, ist_d; // sticky events: rxav, tmo, txe, err
    logic [3:0] imsk_q, imsk_d;
    logic [7:0] rdata_q, rdata_d;
    // timeout counter state, counted in bit ticks
    logic [TMO_W-1:0] tmo_cnt_q, tmo_cnt_d;
    logic tmo_q, tmo_d;
    // transmit empty machinery
    ufi_tx_st_t tx_st_q, tx_st_d;
    logic two_seen_q, two_seen_d;
    logic first_q, first_d;
    logic txe_q, txe_d;
    logic fen_q;
    logic [4:0] trig;
    // declared early: the tx clear path reads the ident code
    logic [3:0] ident_code;
    logic rx_ie, tx_ie, fen, rxav, tx_empty;
    logic [TMO_W-1:0] tmo_lim;
    assign fen = ctrl_q[`UFI_CTRL_FIFO_EN];
    assign rx_ie = ctrl_q[`UFI_CTRL_RX_IE];
    assign tx_ie = ctrl_q[`UFI_CTRL_TX_IE];
    // threshold lookup from trigger field
    always_comb begin
        unique case (ctrl_q[`UFI_CTRL_TRIG_LO +: 2])
            2'h0: trig = `UFI_TRIG0;
            2'h1: trig = `UFI_TRIG1;
            2'h2: trig = `UFI_TRIG2;
            2'h3: trig = `UFI_TRIG3;
        endcase
    end
    assign tx_empty = (fifo.tx_count == 5'h00);
    assign tx_holding_empty_flag = tx_empty;
    assign rx_data_ready_flag = (fifo.rx_count != 5'h00);
    // level follows fifo count directly, so it drops the moment count falls below the trigger threshold
    assign rxav = fen && rx_ie && (fifo.rx_count >= trig);
    // char_bits already includes second stop bit when configured
    assign tmo_lim = TMO_W'(fifo.char_bits) * TMO_W'(`UFI_TMO_CHARS);
    // timeout counter process
    always_comb begin
        tmo_cnt_d = tmo_cnt_q;
        tmo_d = tmo_q;
        if (fifo.rx_char_in || rx_fifo_rd || !fen || fifo.rx_count == 5'h00) begin
            tmo_cnt_d = '0;
            tmo_d = 1'b0;
        end else if (fifo.bit_tick) begin
            if (tmo_cnt_q >= tmo_lim) begin
                tmo_d = rx_ie;
            end else begin
                tmo_cnt_d = tmo_cnt_q + TMO_W'(1);
            end
        end
    end
    // transmit empty delay machine
    always_comb begin
        tx_st_d = tx_st_q;
        two_seen_d = two_seen_q || (fifo.tx_count >= 5'h02);
        first_d = first_q;
        txe_d = txe_q;
        // a host write into the tx fifo drops the indication; a set below wins
        if (tx_fifo_wr) begin
            txe_d = 1'b0;
        end
        if (!fen) begin
            tx_st_d = TX_IDLE;
            first_d = 1'b1;
            txe_d = 1'b0;
        end else if (!tx_empty) begin
            tx_st_d = TX_IDLE;
            txe_d = 1'b0;
        end else begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    if (first_q || two_seen_q) begin
                        tx_st_d = TX_SHOW;
                        txe_d = 1'b1;
                        first_d = 1'b0;
                    end else begin
                        tx_st_d = TX_WAIT;
                    end
                    two_seen_d = 1'b0;
                end
                TX_WAIT: begin
                    // waits for the shifter to reach its last stop bit
                    if (fifo.tx_stop_start) begin
                        tx_st_d = TX_SHOW;
                        txe_d = 1'b1;
                    end
                end
                TX_SHOW: begin
                end
            endcase
        end
        if (rd && addr == `UFI_OFF_IDENT && ident_code == `UFI_CODE_TXE) begin
            txe_d = 1'b0;
        end
    end
    // interrupt identification by priority
    logic txe_on;
    assign txe_on = txe_q && tx_ie && fen;
    always_comb begin
        if (rxav) begin
            ident_code = `UFI_CODE_RXAV;
        end else if (tmo_q) begin
            ident_code = `UFI_CODE_TMO;
        end else if (txe_on) begin
            ident_code = `UFI_CODE_TXE;
        end else begin
            ident_code = `UFI_CODE_NONE;
        end
    end
    assign host_interrupt_line = rxav || tmo_q || txe_on;
    // register file: set beats clear on every sticky bit
    logic [3:0] ev;
    assign ev = {|{err.brk, err.frame, err.parity, err.overrun}, txe_on, tmo_q, rxav};
    always_comb begin
        ctrl_d = ctrl_q;
        imsk_d = imsk_q;
        ist_d = ist_q;
        err_d = err_q;
        rdata_d = 8'h00;
        if (wr && addr == `UFI_OFF_CTRL) begin
            ctrl_d = wdata;
        end
        if (wr && addr == `UFI_OFF_IMASK) begin
            imsk_d = wdata[3:0];
        end
        if (wr && addr == `UFI_OFF_ISTAT) begin
            ist_d = ist_q & ~wdata[3:0];
        end
        if (rd && addr == `UFI_OFF_LSTAT) begin
            err_d = 4'h0;
        end
        err_d = err_d | {err.brk, err.frame, err.parity, err.overrun};
        ist_d = ist_d | ev;
        if (rd) begin
            unique case (addr)
                `UFI_OFF_CTRL: rdata_d = ctrl_q;
                `UFI_OFF_IDENT: rdata_d = {4'h0, ident_code};
                `UFI_OFF_LSTAT: rdata_d = {1'b0, tx_empty, 1'b0, err_q, rx_data_ready_flag};
                `UFI_OFF_ISTAT: rdata_d = {4'h0, ist_q};
                `UFI_OFF_IMASK: rdata_d = {4'h0, imsk_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end
    // all state registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `UFI_CTRL_RESET;
            err_q <= 4'h0;
            ist_q <= 4'h0;
            imsk_q <= 4'h0;
            rdata_q <= 8'h00;
            tmo_cnt_q <= '0;
            tmo_q <= 1'b0;
            tx_st_q <= TX_IDLE;
            two_seen_q <= 1'b0;
            first_q <= 1'b1;
            txe_q <= 1'b0;
            fen_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            err_q <= err_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            rdata_q <= rdata_d;
            tmo_cnt_q <= tmo_cnt_d;
            tmo_q <= tmo_d;
            tx_st_q <= tx_st_d;
            two_seen_q <= two_seen_d;
            first_q <= first_d;
            txe_q <= txe_d;
            fen_q <= fen;
        end
    end
    assign rdata = rdata_q;
    assign irq = |(ist_q & imsk_q);
    // checks
    property p_rdy;
        @(posedge sys_clk) disable iff (rst) rx_data_ready_flag == (fifo.rx_count != 5'h00);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready flag wrong");
    property p_host_interrupt_line;
        @(posedge sys_clk) disable iff (rst)
            (fen && rx_ie && fifo.rx_count >= trig) |-> host_interrupt_line;
    endproperty
    a_host_interrupt_line: assert property (p_host_interrupt_line) else $error("host_interrupt_line missing");
    property p_host_interrupt_line_off;
        @(posedge sys_clk) disable iff (rst)
            (!tmo_q && !txe_on && fifo.rx_count < trig) |-> !host_interrupt_line;
    endproperty
    a_host_interrupt_line_off: assert property (p_host_interrupt_line_off) else $error("host_interrupt_line stuck");
    property p_code;
        @(posedge sys_clk) disable iff (rst) rxav |-> ident_code == `UFI_CODE_RXAV;
    endproperty
    a_code: assert property (p_code) else $error("rx code wrong");
    property p_tmo_clr;
        @(posedge sys_clk) disable iff (rst) (ce && fifo.rx_char_in) |=> !tmo_q;
    endproperty
    a_tmo_clr: assert property (p_tmo_clr) else $error("timeout not cleared");
    property p_tmo_empty;
        @(posedge sys_clk) disable iff (rst) tmo_q |-> $past(fifo.rx_count) != 5'h00;
    endproperty
    a_tmo_empty: assert property (p_tmo_empty) else $error("timeout on empty");
    property p_txe_clr;
        @(posedge sys_clk) disable iff (rst) (ce && !tx_empty) |=> !txe_q;
    endproperty
    a_txe_clr: assert property (p_txe_clr) else $error("tx empty not cleared");
    property p_lstat;
        @(posedge sys_clk) disable iff (rst)
            (ce && rd && addr == `UFI_OFF_LSTAT && err == '0) |=> err_q == 4'h0;
    endproperty
    a_lstat: assert property (p_lstat) else $error("errors not cleared");
    property p_first;
        @(posedge sys_clk) disable iff (rst)
            (ce && fen && !fen_q && tx_empty && tx_st_q == TX_IDLE) |=> txe_q;
    endproperty
    a_first: assert property (p_first) else $error("first tx late");

    // second group of checks: gating, tx delay, bus side effects
    // rx code needs fifo mode and the rx enable
    property p_rx_gate;
        @(posedge sys_clk) disable iff (rst)
            !(fen && rx_ie) |-> !rxav;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx code while disabled");

    // rx code gone once the count is under the threshold
    property p_rxav_off;
        @(posedge sys_clk) disable iff (rst)
            (fifo.rx_count < trig) |-> ident_code != `UFI_CODE_RXAV;
    endproperty
    a_rxav_off: assert property (p_rxav_off) else $error("rx code stuck");

    // a host read of the rx fifo restarts the idle count
    property p_tmo_rd;
        @(posedge sys_clk) disable iff (rst)
            (ce && rx_fifo_rd) |=> !tmo_q;
    endproperty
    a_tmo_rd: assert property (p_tmo_rd) else $error("timeout after host read");

    // timeout only rises once the full character budget is spent
    property p_tmo_len;
        @(posedge sys_clk) disable iff (rst)
            $rose(tmo_q) |-> $past(tmo_cnt_q) >= $past(tmo_lim);
    endproperty
    a_tmo_len: assert property (p_tmo_len) else $error("timeout too early");

    // tx code needs fifo mode and the tx enable
    property p_txe_gate;
        @(posedge sys_clk) disable iff (rst)
            !(fen && tx_ie) |-> ident_code != `UFI_CODE_TXE;
    endproperty
    a_txe_gate: assert property (p_txe_gate) else $error("tx code while disabled");

    // tx code shown when nothing of higher priority is pending
    property p_txe_code;
        @(posedge sys_clk) disable iff (rst)
            (txe_on && !rxav && !tmo_q) |-> ident_code == `UFI_CODE_TXE;
    endproperty
    a_txe_code: assert property (p_txe_code) else $error("tx code missing");

    // reading the ident register while it shows tx empty clears it
    property p_ident_rd;
        @(posedge sys_clk) disable iff (rst)
            (ce && rd && addr == `UFI_OFF_IDENT && ident_code == `UFI_CODE_TXE) |=> !txe_q;
    endproperty
    a_ident_rd: assert property (p_ident_rd) else $error("ident read kept tx code");

    // the delayed path shows the code once the last stop bit starts
    property p_wait_show;
        @(posedge sys_clk) disable iff (rst)
            (ce && fen && tx_empty && tx_st_q == TX_WAIT && fifo.tx_stop_start) |=> txe_q;
    endproperty
    a_wait_show: assert property (p_wait_show) else $error("delayed tx code lost");

    // a lone byte leaves the indication waiting, not shown at once
    property p_delay;
        @(posedge sys_clk) disable iff (rst)
            (ce && fen && tx_empty && tx_st_q == TX_IDLE && !first_q && !two_seen_q)
                |=> (tx_st_q == TX_WAIT && !txe_q);
    endproperty
    a_delay: assert property (p_delay) else $error("tx code not delayed");

    // holding empty flag mirrors an empty tx fifo
    property p_hold;
        @(posedge sys_clk) disable iff (rst)
            tx_holding_empty_flag == (fifo.tx_count == 5'h00);
    endproperty
    a_hold: assert property (p_hold) else $error("holding empty flag wrong");

    // a new error wins over a status read in the same cycle
    property p_err_set;
        @(posedge sys_clk) disable iff (rst)
            (ce && err.overrun) |=> err_q[0];
    endproperty
    a_err_set: assert property (p_err_set) else $error("overrun lost");

    // field value two selects the eight byte threshold
    property p_trig;
        @(posedge sys_clk) disable iff (rst)
            (ctrl_q[`UFI_CTRL_TRIG_LO +: 2] == 2'h2) |-> trig == 5'h08;
    endproperty
    a_trig: assert property (p_trig) else $error("threshold wrong");

    // clock enable low must freeze the register state
    property p_freeze;
        @(posedge sys_clk) disable iff (rst)
            !ce |=> ($stable(ctrl_q) && $stable(ist_q) && $stable(txe_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    // covers for the immediate and delayed tx paths, rx available, timeout and the status interrupt
    c_first: cover property (@(posedge sys_clk) ce && fen && !fen_q ##1 txe_q);
    c_irq: cover property (@(posedge sys_clk) irq);
    c_rxav: cover property (@(posedge sys_clk) rxav);
    c_tmo: cover property (@(posedge sys_clk) tmo_q);
    c_wait: cover property (@(posedge sys_clk) tx_st_q == TX_WAIT ##1 tx_st_q == TX_SHOW);
endmodule
`default_nettype wire

// file: logic/ufi_regs.svh
`ifndef UFI_REGS_SVH
`define UFI_REGS_SVH
// register offsets
`define UFI_OFF_CTRL 3'h0
`define UFI_OFF_IDENT 3'h1
`define UFI_OFF_LSTAT 3'h2
`define UFI_OFF_ISTAT 3'h3
`define UFI_OFF_IMASK 3'h4
// control fields
`define UFI_CTRL_FIFO_EN 0
`define UFI_CTRL_RX_IE 1
`define UFI_CTRL_TX_IE 2
`define UFI_CTRL_TRIG_LO 6
// identification codes
`define UFI_CODE_NONE 4'h1
`define UFI_CODE_RXAV 4'h4
`define UFI_CODE_TMO 4'hc
`define UFI_CODE_TXE 4'h2
// trigger thresholds
`define UFI_TRIG0 5'h01
`define UFI_TRIG1 5'h04
`define UFI_TRIG2 5'h08
`define UFI_TRIG3 5'h0e
// timeout length in character times
`define UFI_TMO_CHARS 3'h4
`define UFI_CTRL_RESET 8'h00
`endif

// file: logic/ufi_pkg.sv
package ufi_pkg;
    // fifo occupancy and character-time inputs
    typedef struct packed {
        logic [4:0] rx_count;
        logic [4:0] tx_count;
        logic rx_char_in;
        logic tx_stop_start;
        logic bit_tick;
        logic [3:0] char_bits;
    } ufi_fifo_t;
    // error events from the receiver
    typedef struct packed {
        logic brk;
        logic frame;
        logic parity;
        logic overrun;
    } ufi_err_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHOW} ufi_tx_st_t;
endpackage

// file: verif/ufi_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the register bus, one strobe per access
module ufi_host (
    input wire logic sys_clk,
    output logic ce,
    output logic [2:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    // bus idle at time zero, clock enable always on
    initial begin
        ce = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one-cycle write, slave never stalls
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
        wdata <= ~v; // stale data must not be reused
    endtask
    // read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufi_regs.svh"
module tb_top;
    import ufi_pkg::*;
    logic sys_clk, rst, ce, wr, rd, rx_fifo_rd, tx_fifo_wr, irq_a;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    ufi_fifo_t fifo; // occupancy and bit timing stimulus
    ufi_err_t err;
    logic rx_data_ready_flag, tx_holding_empty_flag, host_interrupt_line, irq;
    int mismatches, checked, seed, n, rx, f;
    int trig_tab[4] = '{1, 4, 8, 14}; // thresholds per trigger field
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ufi_core #(.TMO_W(8)) u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo(fifo), .err(err),
        .rx_fifo_rd(rx_fifo_rd), .tx_fifo_wr(tx_fifo_wr),
        .rx_data_ready_flag(rx_data_ready_flag),
        .tx_holding_empty_flag(tx_holding_empty_flag),
        .host_interrupt_line(host_interrupt_line), .irq(irq));
    ufi_host u_host (.sys_clk(sys_clk), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    // model of the rx-available identification
    function automatic logic [3:0] exp_code(int cnt, int trig, bit en);
        return (en && cnt >= trig) ? `UFI_CODE_RXAV : `UFI_CODE_NONE;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // hang guard, counts as a mismatch
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        seed = 63;
        rst = 1'b1;
        fifo = '0;
        err = '0;
        rx_fifo_rd = 1'b0;
        tx_fifo_wr = 1'b0;
        tick(2);
        rst = 1'b0;
        u_host.bus_rd(`UFI_OFF_CTRL, d);
        chk("ctrl reset", d, `UFI_CTRL_RESET);
        chk("irq reset", irq, 8'h00);
        u_host.bus_rd(3'h7, d);
        chk("unmapped", d, 8'h00);
        // first tx interrupt right after enabling fifo mode
        u_host.bus_wr(`UFI_OFF_CTRL, 8'h05);
        u_host.bus_rd(`UFI_OFF_IDENT, d);
        chk("first txe", d[3:0], `UFI_CODE_TXE);
        chk("hold empty", tx_holding_empty_flag, 8'h01);
        u_host.bus_rd(`UFI_OFF_IDENT, d);
        chk("txe cleared", d[3:0], `UFI_CODE_NONE);
        $display("test tx empty done");
        // trigger levels around the threshold, enable on and off
        for (n = 0; n < 16; n++) begin
            f = n % 4;
            rx = trig_tab[f] + ($random(seed) % 2);
            fifo.rx_count <= rx[4:0];
            u_host.bus_wr(`UFI_OFF_CTRL, {f[1:0], 4'h0, 1'(n < 12), 1'b1});
            u_host.bus_rd(`UFI_OFF_IDENT, d);
            chk("ident", d[3:0], exp_code(rx, trig_tab[f], n < 12));
            chk("ready", rx_data_ready_flag, 8'(rx != 0));
            chk("host_interrupt_line", host_interrupt_line, 8'(n < 12 && rx >= trig_tab[f]));
        end
        $display("test trigger done");
        // timeout with ten-bit characters, two stop bits included
        fifo.char_bits <= 4'ha;
        fifo.rx_count <= 5'h01;
        u_host.bus_wr(`UFI_OFF_CTRL, 8'hc3);
        fifo.rx_char_in <= 1'b1;
        tick(1);
        fifo.rx_char_in <= 1'b0;
        fifo.bit_tick <= 1'b1;
        tick(30);
        u_host.bus_rd(`UFI_OFF_IDENT, d);
        chk("no early tmo", d[3:0], `UFI_CODE_NONE);
        tick(20);
        u_host.bus_rd(`UFI_OFF_IDENT, d);
        chk("tmo", d[3:0], `UFI_CODE_TMO);
        rx_fifo_rd <= 1'b1;
        tick(1);
        rx_fifo_rd <= 1'b0;
        u_host.bus_rd(`UFI_OFF_IDENT, d);
        chk("tmo restart", d[3:0], `UFI_CODE_NONE);
        fifo.bit_tick <= 1'b0;
        fifo.rx_count <= 5'h00;
        $display("test timeout done");
        // error flags, sticky status, mask and interrupt
        err.overrun <= 1'b1;
        err.brk <= 1'b1;
        tick(1);
        err <= '0;
        u_host.bus_rd(`UFI_OFF_LSTAT, d);
        chk("errors", d[4:1], 4'h9);
        u_host.bus_rd(`UFI_OFF_LSTAT, d);
        chk("errors clr", d[4:1], 4'h0);
        u_host.bus_rd(`UFI_OFF_ISTAT, d);
        chk("err sticky", d[3], 8'h01);
        u_host.bus_wr(`UFI_OFF_IMASK, 8'h00);
        tick(1);
        irq_a = irq;
        u_host.bus_wr(`UFI_OFF_IMASK, 8'hff);
        tick(1);
        chk("mask", irq ^ irq_a, 8'h01);
        u_host.bus_wr(`UFI_OFF_ISTAT, 8'hff);
        u_host.bus_rd(`UFI_OFF_ISTAT, d);
        chk("w1c", d[3], 8'h00);
        chk("irq clr", irq, 8'h00);
        $display("test irq done");
        report_and_stop();
    end
endmodule
`default_nettype wire
